// [bridge_ctl_defs.svh]
// offsets, field positions and reset values of the secondary bus control block
`ifndef BRIDGE_CTL_DEFS_SVH
`define BRIDGE_CTL_DEFS_SVH

`define OFS_CONTROL        8'h00
`define OFS_IRQ_STATUS     8'h04
`define OFS_IRQ_MASK       8'h08
`define OFS_STATE          8'h0C

`define BIT_BACK_TO_BACK   7
`define BIT_DOWNSTREAM_RST 6
`define BIT_ABORT_REPORT   5
`define BIT_VIDEO_FULL     4

`define CONTROL_RESET      16'h0000
`define CONTROL_RW_MASK    16'h00F0
`define IRQ_RESET          4'h0

`define EV_UR_REPORTED     0
`define EV_TARGET_ABORT    1
`define EV_POSTED_ERROR    2
`define EV_SILENT_ABORT    3

`define ST_RESET_ACTIVE    0
`define ST_VIDEO_ENABLE    1
`define ST_VIDEO_HIT       2

`define ABORT_READ_DATA    32'hFFFFFFFF
`define VIDEO_LO_FIRST     10'h3B0
`define VIDEO_LO_LAST      10'h3BB
`define VIDEO_HI_FIRST     10'h3C0
`define VIDEO_HI_LAST      10'h3DF

`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2

`endif

// [bridge_ctl_pkg.sv]
// types shared by the secondary bus control block
package bridge_ctl_pkg;
  typedef logic [31:0] word_t;
  typedef logic [7:0]  axi_addr_t;
  typedef logic [1:0]  axi_resp_t;
  typedef logic [3:0]  event_t;
endpackage

// [legacy_video_decoder.sv]
// legacy video i/o address decoder with optional alias checking
`include "bridge_ctl_defs.svh"

module legacy_video_decoder
(
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire bridge_ctl_pkg::word_t io_addr,
  input  wire logic                  io_addr_valid,
  input  wire logic                  video_enable,
  input  wire logic                  full_decode,
  output logic                       video_io_hit
);
  import bridge_ctl_pkg::*;

  wire       first_64k;
  wire       low_range;
  wire       alias_ok;
  wire       hit_next;
  wire [9:0] low_bits;

  assign low_bits  = io_addr[9:0];
  assign first_64k = (io_addr[31:16] == 16'h0000);
  assign low_range = ((low_bits >= `VIDEO_LO_FIRST) && (low_bits <= `VIDEO_LO_LAST))
                  || ((low_bits >= `VIDEO_HI_FIRST) && (low_bits <= `VIDEO_HI_LAST)); // (RQ9)
  // aliases at [15:10] are only rejected when full decoding is on
  assign alias_ok  = !full_decode || (io_addr[15:10] == 6'h00); // (RQ7)
  assign hit_next  = io_addr_valid && video_enable && first_64k && low_range && alias_ok; // (RQ8)

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      video_io_hit <= 1'b0;
    else
      video_io_hit <= hit_next;
  end

  a_hit_needs_enable: assert property (@(posedge aclk) disable iff (!aresetn)
    video_io_hit |-> $past(video_enable)) else $error("video hit without enable"); // (RQ8)
  a_alias_checked: assert property (@(posedge aclk) disable iff (!aresetn)
    (io_addr_valid && video_enable && full_decode && io_addr[15:10] != 6'h00)
      |=> !video_io_hit) else $error("alias accepted under full decode"); // (RQ7)
  a_alias_ignored: assert property (@(posedge aclk) disable iff (!aresetn)
    (io_addr_valid && video_enable && !full_decode && io_addr[31:16] == 16'h0000
      && io_addr[9:0] == 10'h3C5) |=> video_io_hit) else $error("alias not forwarded"); // (RQ9)
endmodule

// [bridge_ctl.sv]
// secondary bus control bits 7..4 with axi4-lite access and abort handling
// Functional notes
// (RQ1) back-to-back bit enables fast back-to-back transfers
// (RQ2) reset-request bit holds secondary reset asserted
// (RQ3) mode clear: silent abort, reads all ones
// (RQ4) mode set: pci master abort gives UR
// (RQ5) mode set: UR completion gives target abort
// (RQ6) mode set: posted write abort signals error
// (RQ7) full decode compares address bits 15..10
// (RQ8) full decode matters only with video enabled
// (RQ9) video i/o ranges 3B0-3BB, 3C0-3DF
// (RQ10) software clears reset bit to release reset
`include "bridge_ctl_defs.svh"

module bridge_ctl
(
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  input  wire bridge_ctl_pkg::axi_addr_t s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire bridge_ctl_pkg::word_t     s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output bridge_ctl_pkg::axi_resp_t      s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire bridge_ctl_pkg::axi_addr_t s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output bridge_ctl_pkg::word_t          s_axi_rdata,
  output bridge_ctl_pkg::axi_resp_t      s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  input  wire logic                      legacy_video_enable,
  input  wire bridge_ctl_pkg::word_t     io_addr,
  input  wire logic                      io_addr_valid,
  output logic                           video_io_hit,
  output logic                           back_to_back_enable,
  output logic                           secondary_reset_out_n,
  input  wire logic                      sec_master_abort,
  input  wire logic                      sec_abort_is_read,
  input  wire logic                      sec_abort_is_posted,
  input  wire logic                      pcie_ur_completion,
  input  wire logic                      pcie_ur_is_read,
  output logic                           pcie_ur_status,
  output logic                           sec_target_abort,
  output logic                           posted_write_error,
  output logic                           substitute_read_valid,
  output bridge_ctl_pkg::word_t          substitute_read_data,
  output logic                           write_discard,
  output logic                           irq
);
  import bridge_ctl_pkg::*;

  logic [15:0] control_reg;
  logic [15:0] control_next;
  event_t      status_reg;
  event_t      status_next;
  event_t      mask_reg;
  event_t      mask_next;
  logic        aw_held_reg;
  axi_addr_t   aw_addr_reg;
  logic        w_held_reg;
  word_t       w_data_reg;
  logic [3:0]  w_strb_reg;
  axi_resp_t   bresp_reg;
  logic        bvalid_reg;
  word_t       rdata_reg;
  axi_resp_t   rresp_reg;
  logic        rvalid_reg;
  logic        ur_reg;
  logic        target_abort_reg;
  logic        posted_err_reg;
  logic        substitute_reg;
  logic        discard_reg;
  wire mode_report;
  wire full_decode;
  assign mode_report = control_reg[`BIT_ABORT_REPORT];
  assign full_decode = control_reg[`BIT_VIDEO_FULL];

  wire aw_take;
  wire w_take;
  wire wr_fire;
  wire b_done;
  wire have_aw;
  wire have_w;
  wire [7:0] wr_addr;
  wire [31:0] wr_data;
  wire [3:0] wr_strb;

  // one write in flight: no new address or data until the response is taken
  assign s_axi_awready = !aw_held_reg && !bvalid_reg;
  assign s_axi_wready  = !w_held_reg && !bvalid_reg;
  assign aw_take       = s_axi_awvalid && s_axi_awready;
  assign w_take        = s_axi_wvalid && s_axi_wready;
  assign have_aw       = aw_held_reg || aw_take;
  assign have_w        = w_held_reg || w_take;
  assign wr_fire       = have_aw && have_w && !bvalid_reg;
  assign b_done        = bvalid_reg && s_axi_bready;
  assign wr_addr       = aw_held_reg ? aw_addr_reg : s_axi_awaddr;
  assign wr_data       = w_held_reg ? w_data_reg : s_axi_wdata;
  assign wr_strb       = w_held_reg ? w_strb_reg : s_axi_wstrb;

  wire wr_control;
  wire wr_status;
  wire wr_mask;
  wire wr_state;
  wire wr_mapped;
  assign wr_control = wr_fire && (wr_addr == `OFS_CONTROL);
  assign wr_status  = wr_fire && (wr_addr == `OFS_IRQ_STATUS);
  assign wr_mask    = wr_fire && (wr_addr == `OFS_IRQ_MASK);
  assign wr_state   = wr_fire && (wr_addr == `OFS_STATE);
  assign wr_mapped  = wr_control || wr_status || wr_mask || wr_state;

  // only bits 7..4 are writable here; the rest of the register lives elsewhere
  wire [15:0] byte_mask;
  assign byte_mask    = {{8{wr_strb[1]}}, {8{wr_strb[0]}}} & `CONTROL_RW_MASK;
  assign control_next = wr_control ? ((control_reg & ~byte_mask) | (wr_data[15:0] & byte_mask))
                                   : control_reg; // (RQ10)

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_held_reg  <= 1'b0;
      w_data_reg  <= 32'h00000000;
      w_strb_reg  <= 4'h0;
    end
    else
    begin
      aw_held_reg <= (aw_held_reg || aw_take) && !wr_fire;
      w_held_reg  <= (w_held_reg || w_take) && !wr_fire;
      if (aw_take)
        aw_addr_reg <= s_axi_awaddr;
      if (w_take)
      begin
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= `RESP_OKAY;
    end
    else if (wr_fire)
    begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (b_done)
      bvalid_reg <= 1'b0;
  end

  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp  = bresp_reg;

  wire ma_report;
  wire ma_ur;
  wire ma_posted_err;
  wire ma_silent;
  wire ur_target_abort;
  wire ur_silent;
  wire silent_read;
  wire silent_write;

  assign ma_report       = sec_master_abort && mode_report;
  assign ma_ur           = ma_report && !sec_abort_is_posted; // (RQ4)
  assign ma_posted_err   = ma_report && sec_abort_is_posted; // (RQ6)
  assign ma_silent       = sec_master_abort && !mode_report;
  assign ur_target_abort = pcie_ur_completion && mode_report; // (RQ5)
  assign ur_silent       = pcie_ur_completion && !mode_report;
  assign silent_read     = (ma_silent && sec_abort_is_read) || (ur_silent && pcie_ur_is_read); // (RQ3)
  assign silent_write    = (ma_silent && !sec_abort_is_read)
                        || (ur_silent && !pcie_ur_is_read); // (RQ3)

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ur_reg           <= 1'b0;
      target_abort_reg <= 1'b0;
      posted_err_reg   <= 1'b0;
      substitute_reg   <= 1'b0;
      discard_reg      <= 1'b0;
    end
    else
    begin
      ur_reg           <= ma_ur;
      target_abort_reg <= ur_target_abort;
      posted_err_reg   <= ma_posted_err;
      substitute_reg   <= silent_read;
      discard_reg      <= silent_write;
    end
  end

  assign pcie_ur_status        = ur_reg;
  assign sec_target_abort      = target_abort_reg;
  assign posted_write_error    = posted_err_reg;
  assign substitute_read_valid = substitute_reg;
  assign write_discard         = discard_reg;
  // constant data, so a flop would add nothing but area
  assign substitute_read_data  = `ABORT_READ_DATA; // (RQ3)

  event_t raised;
  assign raised = {silent_read || silent_write, ma_posted_err, ur_target_abort, ma_ur};
  // a new event in the clearing cycle survives the clear
  assign status_next = (status_reg & ~(wr_status ? wr_data[3:0] : 4'h0)) | raised;
  assign mask_next   = wr_mask ? wr_data[3:0] : mask_reg;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      control_reg <= `CONTROL_RESET;
      status_reg  <= `IRQ_RESET;
      mask_reg    <= `IRQ_RESET;
    end
    else
    begin
      control_reg <= control_next;
      status_reg  <= status_next;
      mask_reg    <= mask_next;
    end
  end

  assign irq = |(status_reg & mask_reg);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      back_to_back_enable   <= 1'b0;
      secondary_reset_out_n <= 1'b1;
    end
    else
    begin
      back_to_back_enable   <= control_reg[`BIT_BACK_TO_BACK]; // (RQ1)
      secondary_reset_out_n <= !control_reg[`BIT_DOWNSTREAM_RST]; // (RQ2)
    end
  end

  legacy_video_decoder u_video
  (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .io_addr       (io_addr),
    .io_addr_valid (io_addr_valid),
    .video_enable  (legacy_video_enable),
    .full_decode   (full_decode),
    .video_io_hit  (video_io_hit)
  );

  wire        ar_take;
  wire [31:0] state_word;
  wire [31:0] rd_word;
  wire        rd_mapped;

  assign s_axi_arready = !rvalid_reg;
  assign ar_take       = s_axi_arvalid && s_axi_arready;
  assign state_word    = {29'h00000000, video_io_hit, legacy_video_enable,
                          !secondary_reset_out_n};
  assign rd_mapped     = (s_axi_araddr == `OFS_CONTROL) || (s_axi_araddr == `OFS_IRQ_STATUS)
                      || (s_axi_araddr == `OFS_IRQ_MASK) || (s_axi_araddr == `OFS_STATE);
  assign rd_word       = (s_axi_araddr == `OFS_CONTROL)    ? {16'h0000, control_reg} :
                         (s_axi_araddr == `OFS_IRQ_STATUS) ? {28'h0000000, status_reg} :
                         (s_axi_araddr == `OFS_IRQ_MASK)   ? {28'h0000000, mask_reg} :
                         (s_axi_araddr == `OFS_STATE)      ? state_word : 32'h00000000;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h00000000;
      rresp_reg  <= `RESP_OKAY;
    end
    else if (ar_take)
    begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= rd_word;
      rresp_reg  <= rd_mapped ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (s_axi_rready)
      rvalid_reg <= 1'b0;
  end

  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata  = rdata_reg;
  assign s_axi_rresp  = rresp_reg;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_b2b_follows: assert property (
    back_to_back_enable == $past(control_reg[`BIT_BACK_TO_BACK]))
    else $error("back-to-back output out of step"); // (RQ1)
  a_reset_held: assert property (
    control_reg[`BIT_DOWNSTREAM_RST] [*2] |-> !secondary_reset_out_n)
    else $error("secondary reset released while requested"); // (RQ2)
  a_reset_release: assert property (
    (wr_control && wr_strb[0] && !wr_data[`BIT_DOWNSTREAM_RST]) |=> ##1 secondary_reset_out_n)
    else $error("secondary reset not released after clear"); // (RQ10)
  a_silent_read: assert property (
    (sec_master_abort && !mode_report && sec_abort_is_read)
      |=> substitute_read_valid && !pcie_ur_status && substitute_read_data == 32'hFFFFFFFF)
    else $error("silent read not answered with all ones"); // (RQ3)
  a_silent_write: assert property (
    (pcie_ur_completion && !mode_report && !pcie_ur_is_read)
      |=> write_discard && !sec_target_abort)
    else $error("silent write not dropped"); // (RQ3)
  a_ur_reported: assert property (
    (sec_master_abort && mode_report && !sec_abort_is_posted) |=> pcie_ur_status)
    else $error("master abort not turned into UR"); // (RQ4)
  a_ur_cause: assert property (
    pcie_ur_status |-> $past(mode_report) && $past(sec_master_abort))
    else $error("UR status without reported master abort"); // (RQ4)
  a_target_abort: assert property (
    $rose(sec_target_abort) |-> $past(pcie_ur_completion && mode_report))
    else $error("target abort without UR completion"); // (RQ5)
  a_posted_error: assert property (
    posted_write_error |-> $past(mode_report && sec_abort_is_posted && sec_master_abort))
    else $error("posted error signaled without cause"); // (RQ6)
  a_irq_sticky: assert property (
    (irq && !wr_status && !wr_mask) |=> irq)
    else $error("interrupt dropped without a clear"); // (RQ6)
  a_write_answer: assert property (
    wr_fire |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready)
    else $error("write response missing"); // (RQ10)
endmodule

// [pci_master_model.sv]
// behavioural pci bus master on the secondary side, raising abort events
module pci_master_model
(
  input  wire logic aclk,
  input  wire logic secondary_reset_out_n,
  input  wire logic go,
  input  wire logic go_rd,
  input  wire logic go_ps,
  output logic      sec_master_abort,
  output logic      sec_abort_is_read,
  output logic      sec_abort_is_posted
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    sec_master_abort = 1'b0;
    sec_abort_is_read = 1'b0;
    sec_abort_is_posted = 1'b0;
  end

  // a master held in secondary reset starts nothing
  always @(posedge aclk)
  begin
    sec_master_abort <= go && secondary_reset_out_n;
    // qualifiers wander outside a pulse, so a stale value is never trusted
    sec_abort_is_read <= go ? go_rd : ~sec_abort_is_read;
    sec_abort_is_posted <= go ? go_ps : ~sec_abort_is_posted;
  end
endmodule

// [testbench.sv]
// self-checking bench for the secondary bus control block
`include "bridge_ctl_defs.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import bridge_ctl_pkg::*;

  logic      aclk = 1'b0, aresetn = 1'b0, go = 1'b0, go_rd = 1'b0, go_ps = 1'b0;
  logic      s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic      s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, legacy_video_enable = 1'b0;
  logic      io_addr_valid = 1'b0, pcie_ur_completion = 1'b0, pcie_ur_is_read = 1'b0;
  logic [3:0] s_axi_wstrb = 4'hF;
  axi_addr_t s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  word_t     s_axi_wdata = 32'h0, io_addr = 32'h0, s_axi_rdata, substitute_read_data, rd;
  axi_resp_t s_axi_bresp, s_axi_rresp, resp;
  logic      s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic      video_io_hit, back_to_back_enable, secondary_reset_out_n, pcie_ur_status;
  logic      sec_target_abort, posted_write_error, substitute_read_valid, write_discard;
  logic      irq, sec_master_abort, sec_abort_is_read, sec_abort_is_posted;
  int        fail_count = 0, total_checks = 0;

  always #10 aclk = ~aclk;

  bridge_ctl DUT (.*);

  pci_master_model partner
  (
    .aclk                  (aclk),
    .secondary_reset_out_n (secondary_reset_out_n),
    .go                    (go),
    .go_rd                 (go_rd),
    .go_ps                 (go_ps),
    .sec_master_abort      (sec_master_abort),
    .sec_abort_is_read     (sec_abort_is_read),
    .sec_abort_is_posted   (sec_abort_is_posted)
  );

  task automatic finish_test;
    if (fail_count == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input word_t got, input word_t exp, input string what);
    total_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic axi_wr(input axi_addr_t a, input word_t d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (!(s_axi_bvalid && s_axi_bready));
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_rd(input axi_addr_t a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (!(s_axi_rvalid && s_axi_rready));
    rd = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // registered outputs trail the register by one cycle
  task automatic settle;
    repeat (2) @(posedge aclk);
    @(negedge aclk);
  endtask

  // one abort event; exp is {ur, target abort, posted error, substitute, discard}
  task automatic fire(input logic m, r, p, u, input logic [4:0] exp, input string what);
    logic [4:0] seen;
    seen = 5'h0;
    @(posedge aclk);
    go <= m;
    go_rd <= r;
    go_ps <= p;
    pcie_ur_completion <= u;
    pcie_ur_is_read <= r;
    @(posedge aclk);
    go <= 1'b0;
    pcie_ur_completion <= 1'b0;
    pcie_ur_is_read <= ~r;
    repeat (5)
    begin
      @(negedge aclk);
      seen |= {pcie_ur_status, sec_target_abort, posted_write_error,
               substitute_read_valid, write_discard};
      if (substitute_read_valid) chk(substitute_read_data, `ABORT_READ_DATA, what);
    end
    chk(32'(seen), 32'(exp), what);
  endtask

  function automatic logic exp_hit(input word_t a, input logic en, input logic full);
    logic [9:0] lo;
    lo = a[9:0];
    return en && a[31:16] == 16'h0000 && (!full || a[15:10] == 6'h00)
      && ((lo >= `VIDEO_LO_FIRST && lo <= `VIDEO_LO_LAST)
      || (lo >= `VIDEO_HI_FIRST && lo <= `VIDEO_HI_LAST));
  endfunction

  task automatic t_reset;
    axi_rd(`OFS_CONTROL);
    chk(rd, 32'(`CONTROL_RESET), "control reset");
    axi_rd(`OFS_IRQ_STATUS);
    chk(rd, 32'h0, "status reset");
    axi_rd(`OFS_IRQ_MASK);
    chk(rd, 32'h0, "mask reset");
    axi_rd(`OFS_STATE);
    chk(rd, 32'h0, "state reset");
    chk(back_to_back_enable, 32'h0, "back to back at reset");
    chk(secondary_reset_out_n, 32'h1, "secondary reset idle");
  endtask

  task automatic t_control;
    axi_wr(`OFS_CONTROL, 32'hFFFF_FF80);
    axi_rd(`OFS_CONTROL);
    chk(rd, 32'h80, "only bits 7..4 stick");
    settle;
    chk(back_to_back_enable, 32'h1, "back to back on");
    chk(secondary_reset_out_n, 32'h1, "no reset yet");
    axi_wr(`OFS_CONTROL, 32'h40);
    settle;
    chk(secondary_reset_out_n, 32'h0, "secondary reset driven");
    chk(back_to_back_enable, 32'h0, "back to back off");
    repeat (20) @(posedge aclk);
    chk(secondary_reset_out_n, 32'h0, "reset held while bit set");
    axi_rd(`OFS_STATE);
    chk(32'(rd[`ST_RESET_ACTIVE]), 32'h1, "state shows reset");
    axi_wr(`OFS_CONTROL, 32'h0);
    settle;
    chk(secondary_reset_out_n, 32'h1, "reset released");
  endtask

  task automatic t_abort_silent;
    axi_wr(`OFS_CONTROL, 32'h0);
    fire(1'b1, 1'b1, 1'b0, 1'b0, 5'b00010, "silent read abort");
    fire(1'b1, 1'b0, 1'b0, 1'b0, 5'b00001, "silent write abort");
    fire(1'b1, 1'b0, 1'b1, 1'b0, 5'b00001, "silent posted abort");
    fire(1'b0, 1'b1, 1'b0, 1'b1, 5'b00010, "silent ur completion");
    fire(1'b0, 1'b0, 1'b0, 1'b1, 5'b00001, "silent ur write");
    axi_rd(`OFS_IRQ_STATUS);
    chk(rd, 32'h8, "silent status");
    chk(irq, 32'h0, "masked irq quiet");
    axi_wr(`OFS_IRQ_MASK, 32'h8);
    settle;
    chk(irq, 32'h1, "irq raised");
    axi_wr(`OFS_IRQ_STATUS, 32'h8);
    settle;
    chk(irq, 32'h0, "irq cleared");
    axi_rd(`OFS_IRQ_STATUS);
    chk(rd, 32'h0, "status cleared");
  endtask

  task automatic t_abort_report;
    axi_wr(`OFS_CONTROL, 32'h20);
    fire(1'b1, 1'b1, 1'b0, 1'b0, 5'b10000, "read abort reported");
    fire(1'b1, 1'b0, 1'b0, 1'b0, 5'b10000, "write abort reported");
    fire(1'b1, 1'b0, 1'b1, 1'b0, 5'b00100, "posted abort error");
    fire(1'b0, 1'b0, 1'b0, 1'b1, 5'b01000, "ur gives target abort");
    axi_rd(`OFS_IRQ_STATUS);
    chk(rd, 32'h7, "reported status");
    axi_wr(`OFS_IRQ_STATUS, 32'hF);
    axi_rd(`OFS_IRQ_STATUS);
    chk(rd, 32'h0, "status cleared");
  endtask

  // aliases above bit 9 and one address past the first 64 KB
  task automatic t_video;
    word_t tbl [10] = '{32'h3B0, 32'h3BB, 32'h3BC, 32'h3AF, 32'h3C0, 32'h3DF,
                        32'h3E0, 32'h7B0, 32'hFFC5, 32'h103B0};
    for (int m = 0; m < 4; m++)
    begin
      axi_wr(`OFS_CONTROL, m[0] ? 32'h10 : 32'h0);
      legacy_video_enable <= m[1];
      foreach (tbl[i])
      begin
        @(posedge aclk);
        io_addr <= tbl[i];
        io_addr_valid <= 1'b1;
        @(posedge aclk);
        @(negedge aclk);
        chk(video_io_hit, exp_hit(tbl[i], m[1], m[0]), "video hit");
      end
    end
    @(posedge aclk);
    io_addr_valid <= 1'b0;
    axi_rd(`OFS_STATE);
    chk(32'(rd[`ST_VIDEO_ENABLE]), 32'h1, "state shows video enable");
  endtask

  task automatic t_unmapped;
    axi_rd(8'h10);
    chk(resp, `RESP_SLVERR, "unmapped read response");
    chk(rd, 32'h0, "unmapped read data");
    axi_wr(8'h20, 32'hFFFF_FFFF);
    chk(resp, `RESP_SLVERR, "unmapped write response");
  endtask

  initial
  begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset;
    t_control;
    t_abort_silent;
    t_abort_report;
    t_video;
    t_unmapped;
    finish_test;
  end

  // the whole run needs well under a thousand cycles
  initial
  begin
    #100000;
    fail_count++;
    finish_test;
  end
endmodule
